// ==== hw/flash_host_consts.svh ====
// timing, map and command constants of the paged flash host
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_NS     10
`define T_WP_NS    70
`define T_WPH_NS   100
`define T_ACC_NS   70
`define T_OEHP_NS  150
`define T_BLC_US   200
`define T_PWR_MS   5
`define T_IDP_US   10
`define T_LOCKP_MS 10
`define T_POLL_MS  50
`define UP(ns)     (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CNT_W      5
`define WP_CYC     5'(`UP(`T_WP_NS))
`define WPH_CYC    5'(`UP(`T_WPH_NS))
`define ACC_CYC    5'(`UP(`T_ACC_NS) + 2)
`define OEHP_CYC   5'(`UP(`T_OEHP_NS))
`define BLC_CYC    ((`T_BLC_US * 1000) / `CLK_NS)
`define PWR_CYC    `UP(`T_PWR_MS * 1000000)
`define IDP_CYC    `UP(`T_IDP_US * 1000)
`define LOCKP_CYC  `UP(`T_LOCKP_MS * 1000000)
`define POLL_CYC   ((`T_POLL_MS * 1000000) / `CLK_NS)
`define TMR_W      24
`define PAGE_BYTES 128
`define A_CMD1     18'h05555
`define A_CMD2     18'h02aaa
`define A_BOT      18'h00000
`define A_TOP      18'h3ffff
`define D_AA       8'haa
`define D_55       8'h55
`define D_A0       8'ha0
`define D_80       8'h80
`define D_90       8'h90
`define D_F0       8'hf0
`define D_20       8'h20
`define D_10       8'h10
`define D_60       8'h60
`define D_40       8'h40
`define D_00       8'h00
`define D_FF       8'hff
`define LEN_NONE   3'h0
`define LEN_SHORT  3'h3
`define LEN_LONG   3'h6
`define LEN_LOCK   3'h7
`define TOGGLE_BIT 6
`define R_CTRL     12'h000
`define R_ADDR     12'h004
`define R_BUF      12'h008
`define R_STAT     12'h00c
`define F_OP       3:0
`define F_PROT     4
`define F_LAST     14:8
`define F_BIDX     14:8
`define F_BDAT     7:0
`define F_ADDR     17:0
`define F_PAGE     17:7
`define F_BYTE     6:0
`define ST_DONE    1
`define ST_TOUT    2
`define RESP_OK    2'h0
`define RESP_ERR   2'h2
`endif

// ==== hw/flash_host_pkg.sv ====
// types of the paged flash host
package flash_host_pkg;
	typedef enum logic [3:0] {
		OP_READ    = 4'h0,
		OP_PAGE    = 4'h1,
		OP_UNPROT  = 4'h2,
		OP_ERASE   = 4'h3,
		OP_ID_IN   = 4'h4,
		OP_ID_IN6  = 4'h5,
		OP_ID_OUT  = 4'h6,
		OP_LOCK_LO = 4'h7,
		OP_LOCK_HI = 4'h8,
		OP_ID_PIN  = 4'h9
	} op_t;
	typedef enum logic [2:0] {
		S_PWR = 3'b000, S_IDLE = 3'b001, S_CMD = 3'b010, S_BRD = 3'b011,
		S_DATA = 3'b100, S_POLL = 3'b101, S_PAUSE = 3'b110, S_READ = 3'b111
	} seq_state_t;
	typedef enum logic [1:0] {
		C_IDLE = 2'b00, C_SETUP = 2'b01, C_STB = 2'b10, C_REC = 2'b11
	} cyc_state_t;
endpackage

// ==== hw/flash_cycle_if.sv ====
// one pin cycle request between sequencer and pin driver
`timescale 1ns/1ps
interface flash_cycle_if;
	logic        req;
	logic        wr;
	logic        hv;
	logic [17:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        done;
	modport seq (output req, wr, hv, addr, wdata, input rdata, done);
	modport pins (input req, wr, hv, addr, wdata, output rdata, done);
endinterface

// ==== hw/page_buffer_mem.sv ====
// page image buffer, registered read
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module page_buffer_mem (
	// clock
	input  wire logic       mclk,
	// write port
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata,
	// read port
	input  wire logic [6:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:`PAGE_BYTES-1];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ==== hw/flash_bus_cycle.sv ====
// single read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module flash_bus_cycle
	import flash_host_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// cycle request
	flash_cycle_if.pins      cyc,
	// flash pins
	output logic             ceN,
	output logic             oeN,
	output logic             weN,
	output logic [17:0]      addr,
	output logic [7:0]       dqOut,
	output logic             dqOeN,
	input  wire logic [7:0]  dqIn,
	output logic             idHv
);
	cyc_state_t        stReg, stNext;
	logic [`CNT_W-1:0] tmrReg, tmrNext, lim;
	logic              wrReg, wrNext, hvReg, hvNext;
	logic [17:0]       addrNext;
	logic [7:0]        dataNext, rdReg, rdNext, dqS1, dqS2;
	logic              ceNNext, oeNNext, weNNext, dqOeNNext, idHvNext;

	always_comb begin
		stNext = stReg;
		tmrNext = tmrReg + 5'h1;
		wrNext = wrReg;
		hvNext = hvReg;
		addrNext = addr;
		dataNext = dqOut;
		rdNext = rdReg;
		lim = (stReg == C_STB) ? (wrReg ? `WP_CYC : `ACC_CYC)
			: (wrReg ? `WPH_CYC : `OEHP_CYC);
		case (stReg)
			C_IDLE: begin
				if (cyc.req) begin
					stNext = C_SETUP;
					wrNext = cyc.wr;
					hvNext = cyc.hv;
					addrNext = cyc.addr;
					dataNext = cyc.wdata;
				end
			end
			C_SETUP: begin
				stNext = C_STB;
				tmrNext = '0;
			end
			C_STB: begin
				if (tmrReg == lim - 5'h1) begin
					stNext = C_REC;
					tmrNext = '0;
					rdNext = dqS2;
				end
			end
			C_REC: begin
				if (tmrReg == lim - 5'h1) begin
					stNext = C_IDLE;
				end
			end
			default: stNext = C_IDLE;
		endcase
		// output gate stays high for the whole write cycle
		ceNNext = !(stNext == C_STB);
		weNNext = !(stNext == C_STB && wrNext);
		oeNNext = !(stNext == C_STB && !wrNext);
		// data held through recovery covers the zero hold time
		dqOeNNext = !(wrNext && stNext != C_IDLE);
		idHvNext = hvNext && !wrNext && stNext != C_IDLE;
	end

	assign cyc.done = (stReg == C_REC) && (tmrReg == lim - 5'h1);
	assign cyc.rdata = rdReg;

	always_ff @(posedge mclk) begin
		// pin input crosses in through two stages
		dqS1 <= dqIn;
		dqS2 <= dqS1;
		if (rst) begin
			stReg <= C_IDLE;
			tmrReg <= '0;
			wrReg <= 1'h0;
			hvReg <= 1'h0;
			addr <= '0;
			dqOut <= '0;
			rdReg <= '0;
			ceN <= 1'h1;
			oeN <= 1'h1;
			weN <= 1'h1;
			dqOeN <= 1'h1;
			idHv <= 1'h0;
		end else begin
			stReg <= stNext;
			tmrReg <= tmrNext;
			wrReg <= wrNext;
			hvReg <= hvNext;
			addr <= addrNext;
			dqOut <= dataNext;
			rdReg <= rdNext;
			ceN <= ceNNext;
			oeN <= oeNNext;
			weN <= weNNext;
			dqOeN <= dqOeNNext;
			idHv <= idHvNext;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_write_gate_high:
	assert property (!weN |-> oeN && !ceN) else $error("strobe with gate low");
	a_strobe_width:
	assert property ($fell(weN) |-> !weN [*7]) else $error("write strobe too short");
	a_write_data_driven:
	assert property (!weN |-> !dqOeN) else $error("strobe without data");
	a_hv_read_only:
	assert property (idHv |-> weN && dqOeN) else $error("id pin raised in write");
endmodule

// ==== hw/paged_flash_host.sv ====
// controller driving a paged flash through its pins
// Contract
// - unloaded page bytes become all ones
// - write cycle: select, strobe low, gate high
// - next byte within byte load window
// - one page address per load, any order
// - protected writes need three byte opener
// - six byte sequence removes protection
// - six byte chip erase, off when locked
// - id entry, maker and device code, exit
// - id codes by raised id pin read
// - protection enable and disable code sequences
// - chip erase code sequence
// - id entry and exit codes, 10 us pause
// - block lock codes then 10 ms pause
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module paged_flash_host
	import flash_host_pkg::*;
#(
	parameter logic [`TMR_W-1:0] PWR_CYC  = `TMR_W'(`PWR_CYC),
	parameter logic [`TMR_W-1:0] LOCK_CYC = `TMR_W'(`LOCKP_CYC),
	parameter logic [`TMR_W-1:0] POLL_CYC = `TMR_W'(`POLL_CYC)
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// register bus
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// flash pins
	output logic             flashCeN,
	output logic             flashOeN,
	output logic             flashWeN,
	output logic [17:0]      flashAddr,
	output logic [7:0]       flashDqOut,
	output logic             flashDqOeN,
	input  wire logic [7:0]  flashDqIn,
	output logic             flashIdHv
);
	flash_cycle_if cyc();

	logic              awHeldReg, awHeldNext, wHeldReg, wHeldNext;
	logic [11:0]       awAddrReg, awAddrNext;
	logic [31:0]       wDataReg, wDataNext, rDataReg, rDataNext;
	logic [3:0]        wStrbReg, wStrbNext;
	logic              bValidReg, bValidNext, rValidReg, rValidNext;
	logic [1:0]        bRespReg, bRespNext, rRespReg, rRespNext;
	logic [17:0]       addrReg, addrNext;
	logic              doWr, busy, goWr, memWe, doneSet, toutSet, doneClr;
	seq_state_t        stReg, stNext;
	op_t               opReg, opNext;
	logic              protReg, protNext, reqReg, reqNext, wrReg, wrNext;
	logic              hvReg, hvNext, firstReg, firstNext;
	logic              doneReg, doneNext, toutReg, toutNext;
	logic [6:0]        lastReg, lastNext, idxReg, idxNext;
	logic [2:0]        stepReg, stepNext;
	logic [`TMR_W-1:0] tmrReg, tmrNext;
	logic [17:0]       cAddrReg, cAddrNext;
	logic [7:0]        cDataReg, cDataNext, rdReg, rdNext, prevReg, prevNext, memRd;

	function automatic logic [2:0] cmdLen(op_t op, logic prot);
		case (op)
			OP_PAGE: cmdLen = prot ? `LEN_SHORT : `LEN_NONE;
			OP_ID_IN, OP_ID_OUT: cmdLen = `LEN_SHORT;
			OP_UNPROT, OP_ERASE, OP_ID_IN6: cmdLen = `LEN_LONG;
			OP_LOCK_LO, OP_LOCK_HI: cmdLen = `LEN_LOCK;
			default: cmdLen = `LEN_NONE;
		endcase
	endfunction

	function automatic logic [25:0] cmdWord(op_t op, logic [2:0] step);
		logic [7:0] code;
		code = `D_40;
		case (step)
			3'h0, 3'h3: cmdWord = {`A_CMD1, `D_AA};
			3'h1, 3'h4: cmdWord = {`A_CMD2, `D_55};
			3'h2: begin
				case (op)
					OP_PAGE: code = `D_A0;
					OP_ID_IN: code = `D_90;
					OP_ID_OUT: code = `D_F0;
					default: code = `D_80;
				endcase
				cmdWord = {`A_CMD1, code};
			end
			3'h5: begin
				case (op)
					OP_UNPROT: code = `D_20;
					OP_ERASE: code = `D_10;
					OP_ID_IN6: code = `D_60;
					default: code = `D_40;
				endcase
				cmdWord = {`A_CMD1, code};
			end
			default: cmdWord = (op == OP_LOCK_HI) ? {`A_TOP, `D_FF} : {`A_BOT, `D_00};
		endcase
	endfunction

	// what follows the command bytes of each order
	function automatic seq_state_t nextOf(op_t op);
		case (op)
			OP_PAGE: nextOf = S_BRD;
			OP_UNPROT, OP_ERASE: nextOf = S_POLL;
			OP_ID_IN, OP_ID_IN6, OP_ID_OUT, OP_LOCK_LO, OP_LOCK_HI: nextOf = S_PAUSE;
			default: nextOf = S_READ;
		endcase
	endfunction

	assign busy = stReg != S_IDLE;
	assign s_axi_awready = !awHeldReg;
	assign s_axi_wready = !wHeldReg;
	assign s_axi_bvalid = bValidReg;
	assign s_axi_bresp = bRespReg;
	assign s_axi_arready = !rValidReg;
	assign s_axi_rvalid = rValidReg;
	assign s_axi_rdata = rDataReg;
	assign s_axi_rresp = rRespReg;
	assign doWr = awHeldReg && wHeldReg && !bValidReg;
	// orders and buffer loads are refused while a sequence runs
	assign goWr = doWr && awAddrReg == `R_CTRL && wStrbReg[0] && !busy;
	assign memWe = doWr && awAddrReg == `R_BUF && wStrbReg[1:0] == 2'h3 && !busy;
	assign doneClr = doWr && awAddrReg == `R_STAT && wStrbReg[0] && wDataReg[`ST_DONE];

	always_comb begin
		awHeldNext = awHeldReg;
		awAddrNext = awAddrReg;
		wHeldNext = wHeldReg;
		wDataNext = wDataReg;
		wStrbNext = wStrbReg;
		bValidNext = bValidReg;
		bRespNext = bRespReg;
		rValidNext = rValidReg;
		rDataNext = rDataReg;
		rRespNext = rRespReg;
		addrNext = addrReg;
		if (s_axi_awvalid && !awHeldReg) begin
			awHeldNext = 1'h1;
			awAddrNext = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeldReg) begin
			wHeldNext = 1'h1;
			wDataNext = s_axi_wdata;
			wStrbNext = s_axi_wstrb;
		end
		if (bValidReg && s_axi_bready) begin
			bValidNext = 1'h0;
		end
		if (doWr) begin
			awHeldNext = 1'h0;
			wHeldNext = 1'h0;
			bValidNext = 1'h1;
			bRespNext = (awAddrReg[11:4] == 8'h0 && awAddrReg[1:0] == 2'h0)
				? `RESP_OK : `RESP_ERR;
			if (awAddrReg == `R_ADDR && !busy && wStrbReg[2:0] == 3'h7) begin
				addrNext = wDataReg[`F_ADDR];
			end
		end
		if (rValidReg && s_axi_rready) begin
			rValidNext = 1'h0;
		end
		if (s_axi_arvalid && !rValidReg) begin
			rValidNext = 1'h1;
			rRespNext = `RESP_OK;
			case (s_axi_araddr)
				`R_CTRL: rDataNext = {17'h0, lastReg, 3'h0, protReg, opReg};
				`R_ADDR: rDataNext = {14'h0, addrReg};
				`R_BUF: rDataNext = 32'h0;
				`R_STAT: rDataNext = {16'h0, rdReg, 5'h0, toutReg, doneReg, busy};
				default: begin
					rDataNext = 32'h0;
					rRespNext = `RESP_ERR;
				end
			endcase
		end
	end

	always_comb begin
		stNext = stReg;
		opNext = opReg;
		protNext = protReg;
		lastNext = lastReg;
		idxNext = idxReg;
		stepNext = stepReg;
		reqNext = reqReg;
		wrNext = wrReg;
		hvNext = hvReg;
		cAddrNext = cAddrReg;
		cDataNext = cDataReg;
		rdNext = rdReg;
		prevNext = prevReg;
		firstNext = firstReg;
		doneSet = 1'h0;
		toutSet = 1'h0;
		tmrNext = (tmrReg != '0) ? tmrReg - `TMR_W'(1) : '0;
		case (stReg)
			S_PWR: begin
				if (tmrReg == '0) begin
					stNext = S_IDLE;
				end
			end
			S_IDLE: begin
				if (goWr) begin
					opNext = op_t'(wDataReg[`F_OP]);
					protNext = wDataReg[`F_PROT];
					lastNext = wDataReg[`F_LAST];
					idxNext = '0;
					stepNext = '0;
					firstNext = 1'h1;
					stNext = (cmdLen(opNext, protNext) != `LEN_NONE) ? S_CMD : nextOf(opNext);
				end
			end
			S_CMD: begin
				if (!reqReg) begin
					reqNext = 1'h1;
					wrNext = 1'h1;
					{cAddrNext, cDataNext} = cmdWord(opReg, stepReg);
				end else if (cyc.done) begin
					reqNext = 1'h0;
					stepNext = stepReg + 3'h1;
					if (stepReg == cmdLen(opReg, protReg) - 3'h1) begin
						stNext = nextOf(opReg);
					end
				end
			end
			S_BRD: stNext = S_DATA;
			S_DATA: begin
				if (!reqReg) begin
					// bytes past the last index are left to the flash fill
					reqNext = 1'h1;
					wrNext = 1'h1;
					cAddrNext = {addrReg[`F_PAGE], idxReg};
					cDataNext = memRd;
				end else if (cyc.done) begin
					reqNext = 1'h0;
					if (idxReg == lastReg) begin
						stNext = S_POLL;
					end else begin
						idxNext = idxReg + 7'h1;
						stNext = S_BRD;
					end
				end
			end
			S_POLL: begin
				if (!reqReg && tmrReg == '0) begin
					stNext = S_IDLE;
					toutSet = 1'h1;
				end else if (!reqReg) begin
					reqNext = 1'h1;
					wrNext = 1'h0;
				end else if (cyc.done) begin
					reqNext = 1'h0;
					firstNext = 1'h0;
					prevNext = cyc.rdata;
					// two equal toggle bits in a row mean the write is over
					if (!firstReg && cyc.rdata[`TOGGLE_BIT] == prevReg[`TOGGLE_BIT]) begin
						stNext = S_IDLE;
						doneSet = 1'h1;
						rdNext = cyc.rdata;
					end
				end
			end
			S_PAUSE: begin
				if (tmrReg == '0) begin
					stNext = S_IDLE;
					doneSet = 1'h1;
				end
			end
			S_READ: begin
				if (!reqReg) begin
					reqNext = 1'h1;
					wrNext = 1'h0;
					hvNext = opReg == OP_ID_PIN;
					cAddrNext = addrReg;
				end else if (cyc.done) begin
					reqNext = 1'h0;
					hvNext = 1'h0;
					rdNext = cyc.rdata;
					stNext = S_IDLE;
					doneSet = 1'h1;
				end
			end
			default: stNext = S_IDLE;
		endcase
		if (stNext != stReg && stNext == S_PAUSE) begin
			tmrNext = (opReg == OP_LOCK_LO || opReg == OP_LOCK_HI)
				? LOCK_CYC : `TMR_W'(`IDP_CYC);
		end else if (stNext != stReg && stNext == S_POLL) begin
			tmrNext = POLL_CYC;
		end
		doneNext = doneSet || (doneReg && !doneClr);
		toutNext = toutSet || (toutReg && !(doneClr && wDataReg[`ST_TOUT]));
	end

	assign cyc.req = reqReg;
	assign cyc.wr = wrReg;
	assign cyc.hv = hvReg;
	assign cyc.addr = cAddrReg;
	assign cyc.wdata = cDataReg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeldReg <= 1'h0;
			awAddrReg <= '0;
			wHeldReg <= 1'h0;
			wDataReg <= '0;
			wStrbReg <= '0;
			bValidReg <= 1'h0;
			bRespReg <= `RESP_OK;
			rValidReg <= 1'h0;
			rDataReg <= '0;
			rRespReg <= `RESP_OK;
			addrReg <= '0;
			stReg <= S_PWR;
			opReg <= OP_READ;
			protReg <= 1'h0;
			lastReg <= '0;
			idxReg <= '0;
			stepReg <= '0;
			reqReg <= 1'h0;
			wrReg <= 1'h0;
			hvReg <= 1'h0;
			cAddrReg <= '0;
			cDataReg <= '0;
			rdReg <= '0;
			prevReg <= '0;
			firstReg <= 1'h0;
			doneReg <= 1'h0;
			toutReg <= 1'h0;
			tmrReg <= PWR_CYC;
		end else begin
			awHeldReg <= awHeldNext;
			awAddrReg <= awAddrNext;
			wHeldReg <= wHeldNext;
			wDataReg <= wDataNext;
			wStrbReg <= wStrbNext;
			bValidReg <= bValidNext;
			bRespReg <= bRespNext;
			rValidReg <= rValidNext;
			rDataReg <= rDataNext;
			rRespReg <= rRespNext;
			addrReg <= addrNext;
			stReg <= stNext;
			opReg <= opNext;
			protReg <= protNext;
			lastReg <= lastNext;
			idxReg <= idxNext;
			stepReg <= stepNext;
			reqReg <= reqNext;
			wrReg <= wrNext;
			hvReg <= hvNext;
			cAddrReg <= cAddrNext;
			cDataReg <= cDataNext;
			rdReg <= rdNext;
			prevReg <= prevNext;
			firstReg <= firstNext;
			doneReg <= doneNext;
			toutReg <= toutNext;
			tmrReg <= tmrNext;
		end
	end

	page_buffer_mem u_buf (
		.mclk  (mclk),
		.we    (memWe),
		.waddr (wDataReg[`F_BIDX]),
		.wdata (wDataReg[`F_BDAT]),
		.raddr (idxReg),
		.rdata (memRd)
	);

	flash_bus_cycle u_cyc (
		.mclk  (mclk),
		.rst   (rst),
		.cyc   (cyc.pins),
		.ceN   (flashCeN),
		.oeN   (flashOeN),
		.weN   (flashWeN),
		.addr  (flashAddr),
		.dqOut (flashDqOut),
		.dqOeN (flashDqOeN),
		.dqIn  (flashDqIn),
		.idHv  (flashIdHv)
	);

	logic [15:0] gapReg;
	always_ff @(posedge mclk) begin
		if (rst || !(stReg == S_BRD || stReg == S_DATA) || cyc.done) begin
			gapReg <= '0;
		end else begin
			gapReg <= gapReg + 16'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_load_gap:
	assert property (gapReg < 16'(`BLC_CYC)) else $error("byte load window missed");
	a_page_same:
	assert property (stReg == S_DATA && reqReg |-> cAddrReg[`F_PAGE] == addrReg[`F_PAGE])
		else $error("page address changed");
	a_last_polled:
	assert property (stReg == S_POLL && opReg == OP_PAGE |-> cAddrReg[`F_BYTE] == lastReg)
		else $error("poll not at last loaded byte");
	a_prefix_first:
	assert property (stReg == S_DATA && protReg |-> stepReg == `LEN_SHORT)
		else $error("data before opener");
	a_unprot_len:
	assert property (stReg == S_POLL && opReg == OP_UNPROT |-> stepReg == `LEN_LONG)
		else $error("disable sequence length");
	a_erase_len:
	assert property (stReg == S_POLL && opReg == OP_ERASE |-> stepReg == `LEN_LONG)
		else $error("erase sequence length");
	a_first_code:
	assert property (stReg == S_CMD && reqReg && stepReg == 3'h0
		|-> cAddrReg == `A_CMD1 && cDataReg == `D_AA) else $error("bad first code");
	a_erase_tail:
	assert property (stReg == S_CMD && reqReg && stepReg == 3'h5 && opReg == OP_ERASE
		|-> cDataReg == `D_10) else $error("bad erase code");
	a_id_pause:
	assert property (stReg == S_PAUSE && $past(stReg) == S_CMD && opReg == OP_ID_OUT
		|-> tmrReg == `TMR_W'(`IDP_CYC) && stepReg == `LEN_SHORT) else $error("id pause");
	a_lock_tail:
	assert property (stReg == S_CMD && reqReg && stepReg == 3'h6 && opReg == OP_LOCK_HI
		|-> cAddrReg == `A_TOP && cDataReg == `D_FF) else $error("bad lock code");
	a_id_hv_read:
	assert property (hvReg |-> !wrReg && opReg == OP_ID_PIN) else $error("id pin misuse");

	c_page_done: cover property (opReg == OP_PAGE && $fell(stReg == S_POLL) && !toutSet);
	c_erase_done: cover property (opReg == OP_ERASE && $fell(stReg == S_POLL));
	c_lock_pause: cover property (opReg == OP_LOCK_LO && $fell(stReg == S_PAUSE));
	c_poll_tout: cover property ($rose(toutReg));
endmodule

// ==== tb/flash_device_model.sv ====
// behavioural paged flash answering the host's pins
`timescale 1ns/1ps
module flash_device_model #(
	parameter int         BLC_NS   = 2000,
	parameter int         WRITE_NS = 5000,
	parameter int         PWR_NS   = 200,
	parameter logic [7:0] MAKER    = 8'h3c,
	parameter logic [7:0] DEVICE   = 8'h7e
)(
	// flash pins
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  dqOut,
	input  wire logic        idHv,
	output logic      [7:0]  dq
);
	logic [7:0]   mem [int];
	logic [7:0]   pg [128];
	logic [127:0] ld;
	logic [22:0]  h [3];
	logic [17:0]  la;
	logic [10:0]  pa;
	logic [7:0]   lastD;
	logic         prot    = 1'b1;
	logic         loading = 1'b0;
	logic         busy    = 1'b0;
	logic         idMode  = 1'b0;
	logic         tog     = 1'b0;
	time          ldT     = 0;
	time          wfT     = 0;
	logic         armed   = 1'b0;
	logic         lockArm = 1'b0;
	logic         lockLo  = 1'b0;
	logic         lockHi  = 1'b0;
	function automatic logic cmd(input logic [7:0] x);
		return h[0] == {15'h5555, 8'haa} && h[1] == {15'h2aaa, 8'h55} && h[2] == {15'h5555, x};
	endfunction
	function automatic logic [7:0] look();
		if (busy)
			return {~lastD[7], tog, lastD[5:0]};
		if (idHv || idMode) begin
			if (addr == 18'h0) return MAKER;
			if (addr == 18'h1) return DEVICE;
			if (addr == 18'h2) return {7'h7f, lockLo};
			if (addr == 18'h3fff2) return {7'h7f, lockHi};
		end
		return mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
	endfunction
	// address on the later fall, data on the earlier rise, gate high only
	always @(negedge weN or negedge ceN) begin
		if (!ceN && !weN) begin
			la = addr;
			armed = 1'b1;
			wfT = $time;
		end
	end
	// both strobes rise in one step, so the write is remembered from the fall
	always @(posedge weN or posedge ceN) begin
		if (armed && oeN && $time - wfT >= 15 && $time >= PWR_NS
			&& !(busy && !loading)) begin
			if (loading || !prot) begin
				pg[la[6:0]] = dqOut;
				ld[la[6:0]] = 1'b1;
				pa = la[17:7];
				lastD = dqOut;
				loading = 1'b1;
				busy = 1'b1;
				ldT = $time;
			end
			h[0] = h[1];
			h[1] = h[2];
			h[2] = {la[14:0], dqOut};
			if (cmd(8'ha0)) begin
				loading = 1'b1;
				busy = 1'b1;
				ld = '0;
				ldT = $time;
			end
			if (cmd(8'h90)) idMode = 1'b1;
			if (cmd(8'hf0)) idMode = 1'b0;
			if (cmd(8'h60)) idMode = 1'b1;
			if (lockArm) begin
				lockLo = lockLo | (la == 18'h0 && dqOut == 8'h00);
				lockHi = lockHi | (la == 18'h3ffff && dqOut == 8'hff);
			end
			lockArm = cmd(8'h40);
		end
		armed = 1'b0;
	end
	always @(negedge oeN or negedge ceN) if (!ceN && !oeN && busy) tog = ~tog;
	initial forever begin
		#100;
		if (loading && $time - ldT > BLC_NS) begin
			loading = 1'b0;
			for (int i = 0; i < 128; i++)
				mem[int'({pa, 7'(i)})] = ld[i] ? pg[i] : 8'hff;
			#WRITE_NS busy = 1'b0;
		end
	end
	// released bus shows a moving pattern, never the last value
	initial forever begin
		#1;
		dq = (!ceN && !oeN) ? look() : ~dq;
	end
endmodule

// ==== tb/tb_paged_flash_host.sv ====
// self-checking bench of the paged flash host
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module tb_paged_flash_host;
	localparam logic [7:0] MK = 8'h3c; // arbitrary value
	localparam logic [7:0] DV = 8'h7e; // arbitrary value
	logic mclk = 0, rst = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ceN, oeN, weN, dqOeN, idHv;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [17:0] fAddr;
	logic [7:0] dqOut, dqIn;
	int fails = 0, comparisons = 0, cycles = 0;
	paged_flash_host #(.PWR_CYC(24'd20), .LOCK_CYC(24'd50), .POLL_CYC(24'd2000)) dut (
		.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr),
		.flashDqOut(dqOut), .flashDqOeN(dqOeN), .flashDqIn(dqIn), .flashIdHv(idHv));
	flash_device_model #(.MAKER(MK), .DEVICE(DV)) flash (
		.ceN(ceN), .oeN(oeN), .weN(weN), .addr(fAddr), .dqOut(dqOut), .idHv(idHv), .dq(dqIn));
	initial forever #5 mclk = ~mclk;
	task automatic complete_run();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under this
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd)) begin
			@(posedge mclk);
			if (s_axi_awready && !ad) begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready && !wd) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge mclk);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// start an order, wait for the sticky done flag, then clear it
	task automatic op(input logic [31:0] c, output logic [31:0] s);
		logic [1:0] r;
		axw(`R_CTRL, c, r);
		s = 0;
		for (int i = 0; i < 1000 && s[1] !== 1'b1; i++) axr(`R_STAT, s, r);
		chk(s[1], 1);
		axw(`R_STAT, 32'h6, r);
	endtask
	task automatic rdAt(input logic [17:0] a, output logic [7:0] v);
		logic [1:0] r;
		logic [31:0] s;
		axw(`R_ADDR, {14'h0, a}, r);
		op(32'h0, s);
		v = s[15:8];
	endtask
	task automatic unmappedAccess();
		logic [1:0] r;
		logic [31:0] d;
		axw(12'h010, 32'h1, r);
		chk(r, 2);
		axr(12'h010, d, r);
		chk(d, 0);
		chk(r, 2);
	endtask
	task automatic pageWrite();
		logic [1:0] r;
		logic [31:0] s;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) axw(`R_BUF, {17'h0, 7'(i), 8'hc3 ^ 8'(i * 9)}, r);
		axw(`R_ADDR, 32'h180, r);
		op(32'h311, s);
		chk(s[15:8], 8'hc3 ^ 8'd27);
		rdAt(18'h182, v);
		chk(v, 8'hc3 ^ 8'd18);
		rdAt(18'h185, v);
		chk(v, 8'hff);
	endtask
	task automatic idModes();
		logic [1:0] r;
		logic [31:0] s;
		logic [7:0] v;
		op(32'h8, s);
		op(32'h4, s);
		rdAt(18'h0, v);
		chk(v, MK);
		rdAt(18'h2, v);
		chk(v, 8'hfe);
		rdAt(18'h3fff2, v);
		chk(v, 8'hff);
		op(32'h6, s);
		rdAt(18'h0, v);
		chk(v, 8'hff);
		op(32'h5, s);
		rdAt(18'h1, v);
		chk(v, DV);
		op(32'h6, s);
		op(32'h3, s);
		axw(`R_ADDR, 32'h1, r);
		op(32'h9, s);
		chk(s[15:8], DV);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 0;
		repeat (30) @(posedge mclk);
		unmappedAccess();
		pageWrite();
		idModes();
		complete_run();
	end
endmodule
